/* bench/line_far_end.sv */
// Far-end line model: alarm levels and B1 error bursts
module line_far_end (
    input  wire logic       clk_in,
    input  wire logic [3:0] alarm_cmd_in,
    input  wire logic [3:0] burst_in,
    output logic      [3:0] alarm_out,
    output logic            b1_error_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] alarm_q = 4'h0;
    logic [3:0] left_q  = 4'h0;
    always @(posedge clk_in) begin
        alarm_q <= alarm_cmd_in;
        left_q  <= (left_q != 4'h0) ? left_q - 4'h1 : burst_in;
    end
    assign alarm_out    = alarm_q;
    assign b1_error_out = (left_q != 4'h0);
endmodule // line_far_end

/* bench/sonet_section_line_overhead_monitor_test.sv */
// Bench for the overhead monitor: registers, alarms, B1 count, transmit path
module sonet_section_line_overhead_monitor_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic sys_clk, rst_n, hsel, hwrite, hready, hresp, b1_err, tx_valid, tx_vo, irq_n;
    logic [9:0] haddr;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata;
    logic [3:0] alarm_cmd, alarm, burst;
    logic [7:0] tx_data;
    logic b2_valid, rate155;
    logic [23:0] b2_err;
    sonet_oh_pkg::tx_byte_t tx_byte;
    int err_count = 0;
    int checks_done = 0;
    line_far_end far (.clk_in(sys_clk), .alarm_cmd_in(alarm_cmd), .burst_in(burst),
        .alarm_out(alarm), .b1_error_out(b1_err));
    sonet_oh_monitor #(.LOF_CYCLES(20)) DUT (.sys_clk_in(sys_clk), .rst_n_in(rst_n),
        .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
        .hsize_in(3'h2), .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
        .hreadyout_out(hready), .hresp_out(hresp), .signal_loss_in(alarm[0]),
        .out_of_frame_in(alarm[1]), .line_ais_in(alarm[2]), .remote_defect_in(alarm[3]),
        .b1_error_in(b1_err), .b2_valid_in(b2_valid), .b2_error_bits_in(b2_err),
        .rate_155_in(rate155), .tx_valid_in(tx_valid), .tx_byte_in(tx_byte),
        .tx_valid_out(tx_vo), .tx_data_out(tx_data), .irq_n_out(irq_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("ERROR %0t got %h exp %h", $time, got, exp);
            err_count++;
        end
    endtask
    task automatic ahb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge sys_clk);
        hsel <= 1'b1; htrans <= 2'h2; hwrite <= w; haddr <= {idx, 2'b00};
        do @(posedge sys_clk); while (hready !== 1'b1);
        hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
        do @(posedge sys_clk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
        logic [31:0] d;
        ahb(1'b1, idx, wd, d);
    endtask
    task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] d;
        ahb(1'b0, idx, 32'h0, d);
        chk(d, exp);
        chk({31'h0, hresp}, 32'h0);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic tx(input sonet_oh_pkg::byte_kind_t k, input logic [7:0] d, e);
        @(posedge sys_clk);
        tx_valid <= 1'b1; tx_byte <= {k, d};
        @(posedge sys_clk);
        tx_valid <= 1'b0;
        #1 chk({24'h0, tx_data}, {24'h0, e});
        chk({31'h0, tx_vo}, 32'h1);
    endtask
    task automatic b2(input logic [23:0] bits);
        @(posedge sys_clk);
        b2_valid <= 1'b1; b2_err <= bits;
        @(posedge sys_clk);
        b2_valid <= 1'b0;
    endtask
    task automatic t_b2;
        rc(8'h1A, 32'h0);
        b2(24'h000103); b2(24'h000000); rc(8'h1A, 32'h1);
        wr(8'h18, 32'h80); b2(24'h800103); rc(8'h1A, 32'h5);
        rate155 <= 1'b0; b2(24'hFF0103); rc(8'h1A, 32'h7);
        rate155 <= 1'b1; wr(8'h18, 32'h0);
    endtask
    task automatic t_regs;
        logic [7:0] ids [5] = '{8'h12, 8'h13, 8'h14, 8'h15, 8'h18};
        foreach (ids[i]) rc(ids[i], 32'h0);
        wr(8'h14, 32'h41); rc(8'h14, 32'h41);
        wr(8'h18, 32'h83); rc(8'h18, 32'h80);
        wr(8'h30, 32'hFF); rc(8'h30, 32'h0);
        alarm_cmd <= 4'hC; wt(10);
        rc(8'h18, 32'h83);
        alarm_cmd <= 4'h0; wt(10); wr(8'h18, 32'h0); wr(8'h14, 32'h0);
    endtask
    task automatic t_los;
        wr(8'h10, 32'h4); alarm_cmd <= 4'h1; wt(10);
        chk({31'h0, irq_n}, 32'h0);
        rc(8'h11, 32'h24);
        rc(8'h11, 32'h04);
        chk({31'h0, irq_n}, 32'h1);
        rc(8'h18, 32'h02);
        alarm_cmd <= 4'h0; wt(10);
        rc(8'h11, 32'h20);
    endtask
    task automatic t_frame;
        alarm_cmd <= 4'h2; wt(10);
        chk({31'h0, irq_n}, 32'h1);
        rc(8'h11, 32'h09);
        wt(30); rc(8'h11, 32'h13);
        rc(8'h18, 32'h02);
        alarm_cmd <= 4'h0; wt(10);
        rc(8'h11, 32'h0A);
        wt(30); rc(8'h11, 32'h10);
    endtask
    task automatic t_b1;
        @(posedge sys_clk) burst <= 4'h5;
        @(posedge sys_clk) burst <= 4'h0;
        wt(8); wr(8'h12, 32'h0); wt(12);
        rc(8'h12, 32'h05);
        rc(8'h13, 32'h00);
        wr(8'h00, 32'h0); wt(12);
        rc(8'h12, 32'h00);
    endtask
    task automatic t_tx;
        wr(8'h14, 32'h40);
        tx(sonet_oh_pkg::KIND_A1_FIRST, 8'hF6, 8'hF6);
        tx(sonet_oh_pkg::KIND_LINE, 8'h5A, 8'h5A);
        wr(8'h15, 32'h1); tx(sonet_oh_pkg::KIND_A1_FIRST, 8'hF6, 8'h76);
        wr(8'h15, 32'h4); tx(sonet_oh_pkg::KIND_LINE, 8'h5A, 8'h00);
        wr(8'h15, 32'h0); wr(8'h14, 32'h41);
        tx(sonet_oh_pkg::KIND_A1_FIRST, 8'hF6, 8'hF6);
        tx(sonet_oh_pkg::KIND_LINE, 8'h12, 8'hFF);
        tx(sonet_oh_pkg::KIND_SOH, 8'h34, 8'h34);
        wr(8'h14, 32'h0); tx(sonet_oh_pkg::KIND_A1_FIRST, 8'hF6, 8'hF6);
        tx(sonet_oh_pkg::KIND_LINE, 8'h00, 8'hFE);
        wr(8'h14, 32'h40); wr(8'h15, 32'h2);
        tx(sonet_oh_pkg::KIND_A1_FIRST, 8'hF6, 8'hF6);
        tx(sonet_oh_pkg::KIND_LINE, 8'h0F, 8'h0F);
        tx(sonet_oh_pkg::KIND_A1_FIRST, 8'hF6, 8'hF6);
        tx(sonet_oh_pkg::KIND_B1, 8'h00, 8'h06);
        wr(8'h15, 32'h0); wr(8'h14, 32'h0);
    endtask
    task automatic complete_run;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    initial begin
        #2_000_000 err_count++;
        complete_run();
    end
    initial begin
        rst_n = 1'b0; hsel = 1'b0; hwrite = 1'b0; haddr = 10'h0; htrans = 2'h0;
        hwdata = 32'h0; alarm_cmd = 4'h0; burst = 4'h0; tx_valid = 1'b0;
        tx_byte = {sonet_oh_pkg::KIND_LINE, 8'h00};
        b2_valid = 1'b0; b2_err = 24'h0; rate155 = 1'b1;
        repeat (20) @(posedge sys_clk);
        rst_n <= 1'b1;
        do @(posedge sys_clk); while (hready !== 1'b1);
        t_regs(); t_los(); t_frame(); t_b1(); t_tx(); t_b2();
        complete_run();
    end
endmodule // sonet_section_line_overhead_monitor_test

/* rtl/frame_scrambler.sv */
// Frame-synchronous x^7+x^6+1 scrambler key generator, one byte per advance
module frame_scrambler (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    input  wire logic       restart_in,
    input  wire logic       advance_in,
    output logic      [7:0] key_out
);
    logic [6:0]  st_q, st_d;
    logic [14:0] step_now;

    function automatic logic [14:0] step8(input logic [6:0] s);
        logic [6:0] t;
        logic [7:0] k;
        t = s;
        k = '0;
        for (int i = 7; i >= 0; i--) begin
            k[i] = t[6];
            t    = {t[5:0], t[6] ^ t[5]};
        end
        return {t, k};
    endfunction

    always_comb begin
        st_d = st_q;
        if (restart_in) begin
            st_d = sonet_oh_pkg::SCR_SEED;
        end else if (advance_in) begin
            st_d = step_now[14:8];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_q <= sonet_oh_pkg::SCR_SEED;
        end else begin
            st_q <= st_d;
        end
    end

    assign step_now = step8(st_q);
    assign key_out  = step_now[7:0];
endmodule // frame_scrambler

/* rtl/level_sync.sv */
// Three-stage synchroniser; output follows once stages two and three agree
module level_sync (
    input  wire logic                             clk_in,
    input  wire logic                             rst_n_in,
    input  wire logic [sonet_oh_pkg::SYNC_W-1:0]  async_in,
    output logic      [sonet_oh_pkg::SYNC_W-1:0]  level_out
);
    logic [sonet_oh_pkg::SYNC_W-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

    always_comb begin
        lvl_d = lvl_q;
        for (int i = 0; i < sonet_oh_pkg::SYNC_W; i++) begin
            if (s2_q[i] == s3_q[i]) begin
                lvl_d[i] = s3_q[i];
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            s1_q  <= '0;
            s2_q  <= '0;
            s3_q  <= '0;
            lvl_q <= '0;
        end else begin
            s1_q  <= async_in;
            s2_q  <= s1_q;
            s3_q  <= s2_q;
            lvl_q <= lvl_d;
        end
    end

    assign level_out = lvl_q;
endmodule // level_sync

/* rtl/sonet_oh_monitor.sv */
// Section/line overhead status, B1/B2 counting and transmit overhead control
module sonet_oh_monitor #(
    parameter int LOF_CYCLES = sonet_oh_pkg::LOF_CYCLES
) (
    input  wire logic                             sys_clk_in,
    input  wire logic                             rst_n_in,
    input  wire logic                             hsel_in,
    input  wire logic [sonet_oh_pkg::ADDR_W-1:0]  haddr_in,
    input  wire logic [1:0]                       htrans_in,
    input  wire logic                             hwrite_in,
    input  wire logic [2:0]                       hsize_in,
    input  wire logic                             hready_in,
    input  wire logic [31:0]                      hwdata_in,
    output logic      [31:0]                      hrdata_out,
    output logic                                  hreadyout_out,
    output logic                                  hresp_out,
    input  wire logic                             signal_loss_in,
    input  wire logic                             out_of_frame_in,
    input  wire logic                             line_ais_in,
    input  wire logic                             remote_defect_in,
    input  wire logic                             b1_error_in,
    input  wire logic                             b2_valid_in,
    input  wire logic [sonet_oh_pkg::B2_BITS-1:0] b2_error_bits_in,
    input  wire logic                             rate_155_in,
    input  wire logic                             tx_valid_in,
    input  wire sonet_oh_pkg::tx_byte_t           tx_byte_in,
    output logic                                  tx_valid_out,
    output logic      [7:0]                       tx_data_out,
    output logic                                  irq_n_out
);
    localparam int LOF_CNT_W_L = sonet_oh_pkg::LOF_CNT_W;
    localparam logic [LOF_CNT_W_L-1:0] LOF_LIM = LOF_CNT_W_L'(LOF_CYCLES);

    // Reset release
    logic rst_a_q, rst_b_q, rst_n;
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_a_q <= 1'b0;
            rst_b_q <= 1'b0;
        end else begin
            rst_a_q <= 1'b1;
            rst_b_q <= rst_a_q;
        end
    end
    assign rst_n = rst_b_q;

    // Line status pins
    logic [sonet_oh_pkg::SYNC_W-1:0] pins;
    level_sync u_sync (
        .clk_in    (sys_clk_in),
        .rst_n_in  (rst_n),
        .async_in  ({remote_defect_in, line_ais_in, out_of_frame_in, signal_loss_in}),
        .level_out (pins)
    );

    function automatic logic [4:0] popcount(input logic [sonet_oh_pkg::B2_BITS-1:0] v);
        logic [4:0] n;
        n = '0;
        for (int i = 0; i < sonet_oh_pkg::B2_BITS; i++) begin
            n = n + 5'(v[i]);
        end
        return n;
    endfunction

    // Bus address phase
    logic                   acc, rd_stat, xfer_go;
    logic [7:0]             idx;
    logic                   wr_pend_q, wr_pend_d;
    logic [7:0]             wr_idx_q, wr_idx_d;
    logic [31:0]            hrdata_q, hrdata_d;
    assign acc     = hsel_in && htrans_in[1] && hready_in;
    assign idx     = haddr_in[sonet_oh_pkg::ADDR_W-1:2];
    assign rd_stat = acc && !hwrite_in && idx == sonet_oh_pkg::IDX_RX_STAT;
    assign xfer_go = wr_pend_q && (wr_idx_q == sonet_oh_pkg::IDX_GLOBAL
                     || wr_idx_q == sonet_oh_pkg::IDX_B1_LO
                     || wr_idx_q == sonet_oh_pkg::IDX_B1_HI);

    // Software control registers
    logic [2:0] irq_en_q, irq_en_d;
    logic [1:0] tx_ctrl_q, tx_ctrl_d;
    logic [2:0] inj_q, inj_d;
    logic       b2_mode_q, b2_mode_d;

    // Alarm state
    logic                   los_q, los_d, oof_q, oof_d, lof_q, lof_d;
    logic                   line_alarm_insert_q, line_alarm_insert_d, rdi_q, rdi_d;
    logic [2:0]             chg_q, chg_d, chg_set;
    logic [LOF_CNT_W_L-1:0] lof_cnt_q, lof_cnt_d;
    logic                   irq_n_q, irq_n_d;

    // Counters
    logic [sonet_oh_pkg::B1_W-1:0]       b1_acc_q, b1_acc_d, b1_snap_q, b1_snap_d;
    logic [sonet_oh_pkg::B2_W-1:0]       b2_cnt_q, b2_cnt_d;
    logic [sonet_oh_pkg::XFER_CNT_W-1:0] xfer_cnt_q, xfer_cnt_d;
    logic [sonet_oh_pkg::B2_BITS-1:0]    b2_bits;

    always_comb begin
        wr_pend_d = acc && hwrite_in;
        wr_idx_d  = acc ? idx : wr_idx_q;
        hrdata_d  = hrdata_q;
        irq_en_d  = irq_en_q;
        tx_ctrl_d = tx_ctrl_q;
        inj_d     = inj_q;
        b2_mode_d = b2_mode_q;
        if (wr_pend_q) begin
            unique case (wr_idx_q)
                sonet_oh_pkg::IDX_RX_CTRL: irq_en_d = hwdata_in[2:0];
                sonet_oh_pkg::IDX_TX_CTRL: tx_ctrl_d = {hwdata_in[sonet_oh_pkg::BIT_SCR_DIS],
                                                        hwdata_in[sonet_oh_pkg::BIT_AIS_INS]};
                sonet_oh_pkg::IDX_TX_INJ:  inj_d = hwdata_in[2:0];
                sonet_oh_pkg::IDX_LINE_CS: b2_mode_d = hwdata_in[sonet_oh_pkg::BIT_B2_MODE];
                default: ;
            endcase
        end
        if (acc && !hwrite_in) begin
            hrdata_d = '0;
            unique case (idx)
                sonet_oh_pkg::IDX_RX_CTRL: hrdata_d[2:0] = irq_en_q;
                sonet_oh_pkg::IDX_RX_STAT: hrdata_d[5:0] = {chg_q, los_q, lof_q, oof_q};
                sonet_oh_pkg::IDX_B1_LO:   hrdata_d[7:0] = b1_snap_q[7:0];
                sonet_oh_pkg::IDX_B1_HI:   hrdata_d[7:0] = b1_snap_q[15:8];
                sonet_oh_pkg::IDX_TX_CTRL: begin
                    hrdata_d[sonet_oh_pkg::BIT_SCR_DIS] = tx_ctrl_q[1];
                    hrdata_d[sonet_oh_pkg::BIT_AIS_INS] = tx_ctrl_q[0];
                end
                sonet_oh_pkg::IDX_TX_INJ:  hrdata_d[2:0] = inj_q;
                sonet_oh_pkg::IDX_LINE_CS: begin
                    hrdata_d[sonet_oh_pkg::BIT_B2_MODE] = b2_mode_q;
                    hrdata_d[sonet_oh_pkg::BIT_LINE_ALARM_INSERT]    = line_alarm_insert_q;
                    hrdata_d[sonet_oh_pkg::BIT_RDI]     = rdi_q;
                end
                sonet_oh_pkg::IDX_B2_CNT:  hrdata_d[sonet_oh_pkg::B2_W-1:0] = b2_cnt_q;
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= sonet_oh_pkg::IDX_GLOBAL;
            hrdata_q  <= '0;
            irq_en_q  <= sonet_oh_pkg::REG_RESET[2:0];
            tx_ctrl_q <= sonet_oh_pkg::REG_RESET[1:0];
            inj_q     <= sonet_oh_pkg::REG_RESET[2:0];
            b2_mode_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_idx_q  <= wr_idx_d;
            hrdata_q  <= hrdata_d;
            irq_en_q  <= irq_en_d;
            tx_ctrl_q <= tx_ctrl_d;
            inj_q     <= inj_d;
            b2_mode_q <= b2_mode_d;
        end
    end

    assign hrdata_out    = hrdata_q;
    assign hreadyout_out = rst_n;
    assign hresp_out     = 1'b0;

    // Alarm tracking, change flags and interrupt
    always_comb begin
        los_d  = pins[0];
        oof_d  = pins[1];
        rdi_d  = pins[3];
        lof_d  = lof_q;
        lof_cnt_d = '0;
        if (oof_q != lof_q) begin
            if (lof_cnt_q == LOF_LIM) begin
                lof_d = oof_q;
            end else begin
                lof_cnt_d = lof_cnt_q + 1'b1;
            end
        end
        line_alarm_insert_d = pins[2] || los_q || lof_q;
        chg_set[sonet_oh_pkg::ALM_LOS] = los_d != los_q;
        chg_set[sonet_oh_pkg::ALM_LOF] = lof_d != lof_q;
        chg_set[sonet_oh_pkg::ALM_OOF] = oof_d != oof_q;
        chg_d = (rd_stat ? 3'h0 : chg_q) | chg_set;
        irq_n_d = !(|(chg_q & irq_en_q));
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            los_q     <= 1'b0;
            oof_q     <= 1'b0;
            lof_q     <= 1'b0;
            rdi_q     <= 1'b0;
            line_alarm_insert_q    <= 1'b0;
            lof_cnt_q <= '0;
            chg_q     <= '0;
            irq_n_q   <= 1'b1;
        end else begin
            los_q     <= los_d;
            oof_q     <= oof_d;
            lof_q     <= lof_d;
            rdi_q     <= rdi_d;
            line_alarm_insert_q    <= line_alarm_insert_d;
            lof_cnt_q <= lof_cnt_d;
            chg_q     <= chg_d;
            irq_n_q   <= irq_n_d;
        end
    end

    assign irq_n_out = irq_n_q;

    // B1 interval counter and B2 counter
    assign b2_bits = rate_155_in ? b2_error_bits_in
                   : {16'h0000, b2_error_bits_in[sonet_oh_pkg::B2_BITS_LOW-1:0]};

    always_comb begin
        b1_acc_d   = b1_acc_q + sonet_oh_pkg::B1_W'(b1_error_in);
        b1_snap_d  = b1_snap_q;
        xfer_cnt_d = xfer_cnt_q;
        if (xfer_go) begin
            xfer_cnt_d = sonet_oh_pkg::XFER_CNT_W'(sonet_oh_pkg::XFER_CYCLES);
        end else if (xfer_cnt_q != '0) begin
            xfer_cnt_d = xfer_cnt_q - 1'b1;
        end
        if (xfer_cnt_q == sonet_oh_pkg::XFER_CNT_W'(1)) begin
            b1_snap_d = b1_acc_q;
            b1_acc_d  = sonet_oh_pkg::B1_W'(b1_error_in);
        end
        b2_cnt_d = b2_cnt_q;
        if (b2_valid_in) begin
            if (b2_mode_q) begin
                b2_cnt_d = b2_cnt_q + sonet_oh_pkg::B2_W'(popcount(b2_bits));
            end else begin
                b2_cnt_d = b2_cnt_q + sonet_oh_pkg::B2_W'(|b2_bits);
            end
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            b1_acc_q   <= '0;
            b1_snap_q  <= '0;
            xfer_cnt_q <= '0;
            b2_cnt_q   <= '0;
        end else begin
            b1_acc_q   <= b1_acc_d;
            b1_snap_q  <= b1_snap_d;
            xfer_cnt_q <= xfer_cnt_d;
            b2_cnt_q   <= b2_cnt_d;
        end
    end

    // Transmit overhead path
    logic       first_a1, is_line, is_framing;
    logic       ais_on_q, ais_on_d, tx_valid_q, tx_valid_d;
    logic [7:0] tx_data_q, tx_data_d, key, mod, scr;
    logic [7:0] b1_run_q, b1_run_d, b1_prev_q, b1_prev_d;

    assign first_a1   = tx_valid_in && tx_byte_in.kind == sonet_oh_pkg::KIND_A1_FIRST;
    assign is_framing = tx_byte_in.kind == sonet_oh_pkg::KIND_A1_FIRST
                     || tx_byte_in.kind == sonet_oh_pkg::KIND_FRAMING;
    assign is_line    = tx_byte_in.kind == sonet_oh_pkg::KIND_LINE;

    frame_scrambler u_scr (
        .clk_in     (sys_clk_in),
        .rst_n_in   (rst_n),
        .restart_in (first_a1),
        .advance_in (tx_valid_in && !is_framing),
        .key_out    (key)
    );

    always_comb begin
        ais_on_d = first_a1 ? tx_ctrl_q[0] : ais_on_q;
        mod      = tx_byte_in.data;
        if (is_line && ais_on_d) begin
            mod = sonet_oh_pkg::AIS_BYTE;
        end
        if (tx_byte_in.kind == sonet_oh_pkg::KIND_B1) begin
            mod = b1_prev_q ^ (inj_q[sonet_oh_pkg::BIT_B1_INV] ? sonet_oh_pkg::INV_MASK
                                                                  : sonet_oh_pkg::ALL_ZERO);
        end
        if (first_a1 && inj_q[sonet_oh_pkg::BIT_FRM_BAD]) begin
            mod[7] = 1'b0;
        end
        scr = (is_framing || tx_ctrl_q[1]) ? mod : mod ^ key;
        b1_run_d  = b1_run_q;
        b1_prev_d = b1_prev_q;
        if (first_a1) begin
            b1_prev_d = b1_run_q;
            b1_run_d  = scr;
        end else if (tx_valid_in) begin
            b1_run_d = b1_run_q ^ scr;
        end
        tx_valid_d = tx_valid_in;
        tx_data_d  = tx_data_q;
        if (inj_q[sonet_oh_pkg::BIT_ZEROS]) begin
            tx_data_d = sonet_oh_pkg::ALL_ZERO;
        end else if (tx_valid_in) begin
            tx_data_d = scr;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            ais_on_q   <= 1'b0;
            b1_run_q   <= '0;
            b1_prev_q  <= '0;
            tx_valid_q <= 1'b0;
            tx_data_q  <= '0;
        end else begin
            ais_on_q   <= ais_on_d;
            b1_run_q   <= b1_run_d;
            b1_prev_q  <= b1_prev_d;
            tx_valid_q <= tx_valid_d;
            tx_data_q  <= tx_data_d;
        end
    end

    assign tx_valid_out = tx_valid_q;
    assign tx_data_out  = tx_data_q;

    // Checks
    sequence seq_xfer_due;
        xfer_cnt_q == sonet_oh_pkg::XFER_CNT_W'(1);
    endsequence
    sequence seq_xfer_armed;
        xfer_go ##1 (xfer_cnt_q != '0);
    endsequence

    AST_LOS_CHG: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (los_d != los_q) |=> chg_q[sonet_oh_pkg::ALM_LOS]) else $error("LOS change flag missed");
    AST_LOF_CHG: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $changed(lof_q) |-> chg_q[sonet_oh_pkg::ALM_LOF]) else $error("LOF change flag missed");
    AST_OOF_CHG: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        $changed(oof_q) |-> chg_q[sonet_oh_pkg::ALM_OOF]) else $error("OOF change flag missed");
    AST_SET_WINS: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (rd_stat && |chg_set) |=> (chg_q & $past(chg_set)) == $past(chg_set))
        else $error("Change lost on status read");
    AST_LOF_SET: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (!lof_q && oof_q && lof_cnt_q == LOF_LIM) |=> lof_q) else $error("LOF not declared");
    AST_LOF_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (lof_q && lof_cnt_q != LOF_LIM) |=> lof_q) else $error("LOF cleared early");
    AST_XFER_TIME: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (xfer_go && xfer_cnt_q == '0) |=> ##9 seq_xfer_due) else $error("B1 transfer late");
    AST_XFER_SNAP: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        seq_xfer_due |=> b1_snap_q == $past(b1_acc_q)) else $error("B1 snapshot wrong");
    AST_XFER_ZERO: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (seq_xfer_due and !xfer_go) |=> b1_acc_q <= 16'h0001) else $error("B1 counter not zeroed");
    AST_ARMED: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        seq_xfer_armed |-> xfer_cnt_q <= sonet_oh_pkg::XFER_CNT_W'(sonet_oh_pkg::XFER_CYCLES))
        else $error("Transfer timer overrange");
    AST_ZEROS: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        inj_q[sonet_oh_pkg::BIT_ZEROS] |=> tx_data_out == 8'h00) else $error("Zeros not forced");
    AST_B2_ONCE: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (b2_valid_in && !b2_mode_q && |b2_bits) |=> b2_cnt_q == $past(b2_cnt_q) + 20'h00001)
        else $error("B2 frame count wrong");
    AST_LINE_ALARM_INSERT: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (los_q || lof_q) |=> line_alarm_insert_q) else $error("Line alarm not raised");
    AST_IRQ: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
        (|(chg_q & irq_en_q)) |=> !irq_n_out) else $error("Interrupt not asserted");
endmodule // sonet_oh_monitor

/* rtl/sonet_oh_pkg.sv */
// Constants, register map and carrier types for the overhead monitor
package sonet_oh_pkg;
    localparam int          ADDR_W        = 10;
    localparam logic [7:0]  IDX_GLOBAL    = 8'h00;
    localparam logic [7:0]  IDX_RX_CTRL   = 8'h10;
    localparam logic [7:0]  IDX_RX_STAT   = 8'h11;
    localparam logic [7:0]  IDX_B1_LO     = 8'h12;
    localparam logic [7:0]  IDX_B1_HI     = 8'h13;
    localparam logic [7:0]  IDX_TX_CTRL   = 8'h14;
    localparam logic [7:0]  IDX_TX_INJ    = 8'h15;
    localparam logic [7:0]  IDX_LINE_CS   = 8'h18;
    localparam logic [7:0]  IDX_B2_CNT    = 8'h1A;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam int          BIT_SCR_DIS   = 6;
    localparam int          BIT_AIS_INS   = 0;
    localparam int          BIT_ZEROS     = 2;
    localparam int          BIT_B1_INV    = 1;
    localparam int          BIT_FRM_BAD   = 0;
    localparam int          BIT_B2_MODE   = 7;
    localparam int          BIT_LINE_ALARM_INSERT      = 1;
    localparam int          BIT_RDI       = 0;
    localparam int          ST_CHG_LSB    = 3;
    localparam int          ALM_LOS       = 2;
    localparam int          ALM_LOF       = 1;
    localparam int          ALM_OOF       = 0;
    localparam int          SYNC_W        = 4;
    localparam int          CLK_HZ        = 10_000_000;
    localparam int          CLK_PERIOD_NS = 100;
    localparam int          LOF_TIME_MS   = 3;
    localparam int          LOF_CYCLES    = LOF_TIME_MS * (CLK_HZ / 1000);
    localparam int          XFER_TIME_NS  = 1000;
    localparam int          XFER_CYCLES   = (XFER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int          LOF_CNT_W     = 16;
    localparam int          XFER_CNT_W    = 4;
    localparam int          B1_W          = 16;
    localparam int          B2_W          = 20;
    localparam int          B2_BITS       = 24;
    localparam int          B2_BITS_LOW   = 8;
    localparam logic [7:0]  AIS_BYTE      = 8'hFF;
    localparam logic [7:0]  ALL_ZERO      = 8'h00;
    localparam logic [7:0]  INV_MASK      = 8'hFF;
    localparam logic [6:0]  SCR_SEED      = 7'h7F;
    typedef enum logic [2:0] {
        KIND_A1_FIRST, KIND_FRAMING, KIND_SOH, KIND_B1, KIND_LINE
    } byte_kind_t;
    typedef struct packed {
        byte_kind_t kind;
        logic [7:0] data;
    } tx_byte_t;
endpackage
